// [rtl/asd_pkg.sv]
// Purpose: shared constants and types for the address space decoder
// Assumes: 32-bit logical byte addresses from the cpu core
// Notes:   all region bounds live here so both design files agree
package asd_pkg;

   localparam int unsigned ADDR_W = 32;

   // top-level areas, by the two high address bits
   localparam logic [1:0] AREA_RESERVED = 2'h2;
   localparam logic [1:0] AREA_SYSTEM   = 2'h3;

   // 8 MB windows inside the user area, by address bits 30..23
   localparam logic [7:0] WIN_ROMEXT = 8'h00;
   localparam logic [7:0] WIN_RAMREG = 8'h01;

   // rom/external block: real 1 MB, offsets within it
   localparam int unsigned ROMEXT_REAL_W = 20;
   localparam logic [19:0] ROM_LAST     = 20'h1FFFF;
   localparam logic [19:0] CSLOW_FIRST  = 20'h20000;
   localparam logic [19:0] CSLOW_LAST   = 20'h7FFFF;
   localparam logic [19:0] CSHIGH_FIRST = 20'h80000;
   localparam logic [19:0] CSHIGH_LAST  = 20'hFFFFF;

   // ram/register block: real 16 KB, offsets within it
   localparam int unsigned RAMREG_REAL_W = 14;
   localparam logic [13:0] PERIPH_LAST = 14'h0FFF;
   localparam logic [13:0] RAM_FIRST   = 14'h1000;
   localparam logic [13:0] RAM_LAST    = 14'h27FF;

   typedef enum logic [1:0] {
      ASD_MODE_SINGLE,
      ASD_MODE_EXPAND,
      ASD_MODE_PROC,
      ASD_MODE_RSVD
   } asd_mode_t;

   typedef enum logic [2:0] {
      ASD_TGT_NONE,
      ASD_TGT_ROM,
      ASD_TGT_CSLOW,
      ASD_TGT_CSHIGH,
      ASD_TGT_RAM,
      ASD_TGT_PERIPH,
      ASD_TGT_RESERVED,
      ASD_TGT_SYSTEM
   } asd_target_t;

endpackage

// [rtl/asd_region_if.sv]
// Purpose: carries one decoded address between the map and the top
// Assumes: driven combinationally by asd_region_map
// Notes:   offsets are already folded to the real block size
`timescale 1ns/1ns
interface asd_region_if;
   logic [31:0]          addr;
   asd_pkg::asd_mode_t   mode;
   asd_pkg::asd_target_t target;
   logic [19:0]          extOffset;
   logic [13:0]          localOffset;
   modport map (input addr, input mode, output target, output extOffset, output localOffset);
   modport user (output addr, output mode, input target, input extOffset, input localOffset);
endinterface

// [rtl/asd_region_map.sv]
// Purpose: pure address-to-target classification
// Assumes: mode is already latched and legal
// Notes:   combinational; the top registers the results
`timescale 1ns/1ns
module asd_region_map (
   asd_region_if.map rgn
);

   logic [19:0] romOfs;
   logic [13:0] regOfs;

   // aliasing: only low bits of each window are decoded
   assign romOfs = rgn.addr[19:0];
   assign regOfs = rgn.addr[13:0];
   assign rgn.extOffset = romOfs;
   assign rgn.localOffset = regOfs;

   always_comb begin
      rgn.target = asd_pkg::ASD_TGT_NONE;
      if (rgn.addr[31:30] == asd_pkg::AREA_RESERVED) begin
         rgn.target = asd_pkg::ASD_TGT_RESERVED;               // see [RULE3]
      end else if (rgn.addr[31:30] == asd_pkg::AREA_SYSTEM) begin
         rgn.target = asd_pkg::ASD_TGT_SYSTEM;                 // see [RULE4]
      end else if (rgn.addr[31] == 1'b0 && rgn.addr[30:23] == asd_pkg::WIN_ROMEXT) begin
         unique case (rgn.mode)                                // see [RULE6]
            asd_pkg::ASD_MODE_SINGLE: begin
               if (romOfs <= asd_pkg::ROM_LAST) begin
                  rgn.target = asd_pkg::ASD_TGT_ROM;           // see [RULE11]
               end
            end
            asd_pkg::ASD_MODE_EXPAND: begin
               if (romOfs <= asd_pkg::ROM_LAST) begin
                  rgn.target = asd_pkg::ASD_TGT_ROM;           // see [RULE8]
               end else if (romOfs <= asd_pkg::CSLOW_LAST) begin
                  rgn.target = asd_pkg::ASD_TGT_CSLOW;         // see [RULE9]
               end else begin
                  rgn.target = asd_pkg::ASD_TGT_CSHIGH;
               end
            end
            asd_pkg::ASD_MODE_PROC: begin
               if (romOfs < asd_pkg::CSHIGH_FIRST) begin
                  rgn.target = asd_pkg::ASD_TGT_CSLOW;         // see [RULE10]
               end else begin
                  rgn.target = asd_pkg::ASD_TGT_CSHIGH;
               end
            end
            default: rgn.target = asd_pkg::ASD_TGT_NONE;
         endcase
      end else if (rgn.addr[31] == 1'b0 && rgn.addr[30:23] == asd_pkg::WIN_RAMREG) begin
         if (regOfs <= asd_pkg::PERIPH_LAST) begin
            rgn.target = asd_pkg::ASD_TGT_PERIPH;              // see [RULE15]
         end else if (regOfs <= asd_pkg::RAM_LAST) begin
            rgn.target = asd_pkg::ASD_TGT_RAM;                 // see [RULE14]
         end
      end
   end

endmodule

// [rtl/address_space_decoder.sv]
// Purpose: decodes cpu logical addresses into target selects
// Assumes: request is a one-cycle strobe with address and write flag
// Notes:   selects come one cycle after the request, from flip-flops
//
// What this block does
// [RULE1] full 32-bit linear address, no banking
// [RULE2] low 2 GB is the user area
// [RULE3] 0x8000_0000 up is reserved, never selected
// [RULE4] 0xC000_0000 up is system, debug only
// [RULE5] two straps pick the operating mode
// [RULE6] only rom/external placement depends on mode
// [RULE7] rom/external window aliases every 1 MB
// [RULE8] internal rom at 0 to 0x1FFFF
// [RULE9] expansion mode: low and high chip selects
// [RULE10] processor mode: no rom, low select from 0
// [RULE11] single-chip mode: no chip select ever
// [RULE12] chip select asserts low with bus strobes
// [RULE13] ram/register window aliases every 16 KB
// [RULE14] 0x80_1000 to 0x80_27FF is internal ram
// [RULE15] 0x80_0000 to 0x80_0FFF is peripheral window
// [RULE16] holes select nothing, writes dropped
`timescale 1ns/1ns
module address_space_decoder (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        mode_strap_a,
   input  wire logic        mode_strap_b,
   input  wire logic        reqValid,
   input  wire logic        reqWrite,
   input  wire logic [31:0] reqAddr,
   output logic             romSelect,
   output logic             ramSelect,
   output logic             peripheralSelect,
   output logic             chip_select_low_region_n,
   output logic             chip_select_high_region_n,
   output logic             extReadStrobe_n,
   output logic             extWriteStrobe_n,
   output logic             targetWrite,
   output logic [19:0]      extAddr,
   output logic [13:0]      localAddr,
   output logic             reservedHit,
   output logic             systemHit,
   output logic             unmappedHit,
   output logic [1:0]       modeOut
);

   ////////////////////////////////////////////////////////////////////////////
   // build-time guards: the map folds addresses into these offset widths and
   // walks each window with one compare chain, so the regions must butt up

   if ($bits(reqAddr) != asd_pkg::ADDR_W
       || $bits(extAddr) != asd_pkg::ROMEXT_REAL_W
       || $bits(localAddr) != asd_pkg::RAMREG_REAL_W) begin : g_width_guard
      $error("offset widths disagree with the folded block sizes");
   end

   if (asd_pkg::CSLOW_FIRST != asd_pkg::ROM_LAST + 20'h00001
       || asd_pkg::CSHIGH_FIRST != asd_pkg::CSLOW_LAST + 20'h00001
       || asd_pkg::CSHIGH_LAST != 20'hFFFFF
       || asd_pkg::RAM_FIRST != asd_pkg::PERIPH_LAST + 14'h0001) begin : g_map_guard
      $error("region bounds leave a gap the compare chains cannot see");
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   // straps read as {a, b}; the reserved code is kept so the map can refuse it
   function automatic asd_pkg::asd_mode_t strap_mode(
      input logic a,
      input logic b
   );
      asd_pkg::asd_mode_t m;
      m = asd_pkg::ASD_MODE_SINGLE;
      unique case ({a, b})
         2'h0: m = asd_pkg::ASD_MODE_SINGLE;
         2'h1: m = asd_pkg::ASD_MODE_EXPAND;
         2'h2: m = asd_pkg::ASD_MODE_PROC;
         2'h3: m = asd_pkg::ASD_MODE_RSVD;
      endcase
      return m;
   endfunction

   // a select line rises only for a request that was taken
   function automatic logic picks(
      input logic                 taken,
      input asd_pkg::asd_target_t have,
      input asd_pkg::asd_target_t want
   );
      return taken && (have == want);
   endfunction

   function automatic logic is_external(
      input asd_pkg::asd_target_t t
   );
      return (t == asd_pkg::ASD_TGT_CSLOW) || (t == asd_pkg::ASD_TGT_CSHIGH);
   endfunction

   // holes, reserved and system addresses have nothing behind them to write
   function automatic logic can_write(
      input asd_pkg::asd_target_t t
   );
      return (t != asd_pkg::ASD_TGT_NONE) && (t != asd_pkg::ASD_TGT_RESERVED)
             && (t != asd_pkg::ASD_TGT_SYSTEM);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // mode strap capture: sampled on the first clock after reset release,
   // so a strap change later cannot move the memory map under software

   asd_pkg::asd_mode_t mode;
   asd_pkg::asd_mode_t next_mode;
   logic               modeTaken;
   logic               next_modeTaken;

   always_comb begin
      next_mode = mode;
      next_modeTaken = modeTaken;
      if (!modeTaken) begin
         next_mode = strap_mode(mode_strap_a, mode_strap_b);   // see [RULE5]
         next_modeTaken = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode <= asd_pkg::ASD_MODE_SINGLE;
         modeTaken <= 1'b0;
      end else begin
         mode <= next_mode;
         modeTaken <= next_modeTaken;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // classification

   asd_region_if rgn ();

   assign rgn.addr = reqAddr;     // see [RULE1] [RULE2]
   assign rgn.mode = mode;

   asd_region_map u_map (
      .rgn (rgn)
   );

   ////////////////////////////////////////////////////////////////////////////
   // registered selects; a request before straps are taken selects nothing

   logic        next_romSelect;
   logic        next_ramSelect;
   logic        next_peripheralSelect;
   logic        next_csLow_n;
   logic        next_csHigh_n;
   logic        next_rd_n;
   logic        next_wr_n;
   logic        next_targetWrite;
   logic [19:0] next_extAddr;
   logic [13:0] next_localAddr;
   logic        next_reservedHit;
   logic        next_systemHit;
   logic        next_unmappedHit;
   logic        live;
   logic        isExt;

   always_comb begin
      live = reqValid && modeTaken;
      isExt = is_external(rgn.target);
      next_romSelect = picks(live, rgn.target, asd_pkg::ASD_TGT_ROM);
      next_ramSelect = picks(live, rgn.target, asd_pkg::ASD_TGT_RAM);
      next_peripheralSelect = picks(live, rgn.target, asd_pkg::ASD_TGT_PERIPH);
      next_csLow_n = !picks(live, rgn.target, asd_pkg::ASD_TGT_CSLOW);     // see [RULE12]
      next_csHigh_n = !picks(live, rgn.target, asd_pkg::ASD_TGT_CSHIGH);
      // strobes only ride with a chip select, so on-chip accesses leave the strobe pins high; extAddr still shows their offset
      next_rd_n = !(live && isExt && !reqWrite);
      next_wr_n = !(live && isExt && reqWrite);
      // writes into holes never reach any target
      next_targetWrite = live && reqWrite && can_write(rgn.target);        // see [RULE16]
      next_extAddr = live ? rgn.extOffset : 20'h00000;                    // see [RULE7]
      next_localAddr = live ? rgn.localOffset : 14'h0000;                 // see [RULE13]
      next_reservedHit = picks(live, rgn.target, asd_pkg::ASD_TGT_RESERVED); // see [RULE3]
      next_systemHit = picks(live, rgn.target, asd_pkg::ASD_TGT_SYSTEM);     // see [RULE4]
      next_unmappedHit = picks(live, rgn.target, asd_pkg::ASD_TGT_NONE);     // see [RULE16]
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         romSelect <= 1'b0;
         ramSelect <= 1'b0;
         peripheralSelect <= 1'b0;
         chip_select_low_region_n <= 1'b1;
         chip_select_high_region_n <= 1'b1;
         extReadStrobe_n <= 1'b1;
         extWriteStrobe_n <= 1'b1;
         targetWrite <= 1'b0;
         extAddr <= 20'h00000;
         localAddr <= 14'h0000;
         reservedHit <= 1'b0;
         systemHit <= 1'b0;
         unmappedHit <= 1'b0;
         modeOut <= 2'h0;
      end else begin
         romSelect <= next_romSelect;
         ramSelect <= next_ramSelect;
         peripheralSelect <= next_peripheralSelect;
         chip_select_low_region_n <= next_csLow_n;
         chip_select_high_region_n <= next_csHigh_n;
         extReadStrobe_n <= next_rd_n;
         extWriteStrobe_n <= next_wr_n;
         targetWrite <= next_targetWrite;
         extAddr <= next_extAddr;
         localAddr <= next_localAddr;
         reservedHit <= next_reservedHit;
         systemHit <= next_systemHit;
         unmappedHit <= next_unmappedHit;
         modeOut <= next_mode;
      end
   end

endmodule

// [bench/asd_chk.sv]
// Purpose: port-level checks of the address space decoder
// Assumes: one clock; a request at the first edge after reset is not taken
// Notes:   answers are registered, so each consequent is one edge later
`timescale 1ns/1ns
module asd_chk (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        reqValid,
   input wire logic [31:0] reqAddr,
   input wire logic        romSelect,
   input wire logic        ramSelect,
   input wire logic        peripheralSelect,
   input wire logic        chip_select_low_region_n,
   input wire logic        chip_select_high_region_n,
   input wire logic        targetWrite,
   input wire logic [19:0] extAddr,
   input wire logic [13:0] localAddr,
   input wire logic        reservedHit,
   input wire logic        systemHit,
   input wire logic        unmappedHit,
   input wire logic [1:0]  modeOut
);
   logic armed;
   logic next_armed;
   // straps are latched at the first edge out of reset, so requests count from the second
   always_comb next_armed = !reset;
   always_ff @(posedge sys_clk) armed <= next_armed;
   wire        take   = armed && reqValid;
   wire        romWin = take && reqAddr[31:23] == 9'h000;
   wire        ramWin = take && reqAddr[31:23] == 9'h001;
   wire [19:0] off    = reqAddr[19:0];
   wire [13:0] loc    = reqAddr[13:0];
   wire        csLow  = !chip_select_low_region_n;
   wire        csHigh = !chip_select_high_region_n;
   wire        anySel = romSelect | ramSelect | peripheralSelect | csLow | csHigh;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   reserved_hit_a: assert property (
      take && reqAddr[31:30] == 2'h2 |=> reservedHit && !anySel && !targetWrite)
      else $error("reserved area not flagged");
   system_hit_a: assert property (
      take && reqAddr[31:30] == 2'h3 |=> systemHit && !anySel && !targetWrite)
      else $error("system area not flagged");
   ram_route_a: assert property (
      ramWin && loc >= 14'h1000 && loc <= 14'h27FF |=> ramSelect && localAddr == $past(loc))
      else $error("ram access misrouted");
   periph_route_a: assert property (
      ramWin && loc[13:12] == 2'h0 |=> peripheralSelect && !ramSelect)
      else $error("peripheral access misrouted");
   ram_hole_a: assert property (
      ramWin && loc >= 14'h2800 |=> unmappedHit && !anySel && !targetWrite)
      else $error("ram block hole selected");
   rom_route_a: assert property (
      romWin && off <= 20'h1FFFF && !modeOut[1] |=> romSelect && !csLow)
      else $error("rom access misrouted");
   cs_low_a: assert property (
      romWin && modeOut == 2'h1 && off >= 20'h20000 && !off[19] |=> csLow && extAddr == $past(off))
      else $error("low chip select missing");
   cs_high_a: assert property (
      romWin && (modeOut == 2'h1 || modeOut == 2'h2) && off[19] |=> csHigh && !csLow)
      else $error("high chip select missing");
   proc_low_a: assert property (
      romWin && modeOut == 2'h2 && !off[19] |=> csLow && !romSelect && extAddr == $past(off))
      else $error("processor mode low select missing");
   single_nocs_a: assert property (
      modeOut == 2'h0 |=> !csLow && !csHigh)
      else $error("chip select in single chip mode");
   idle_clear_a: assert property (
      !reqValid |=> !anySel && !reservedHit && !systemHit && !unmappedHit)
      else $error("select without request");
endmodule
bind address_space_decoder asd_chk u_asd_chk (.sys_clk, .reset, .reqValid, .reqAddr, .romSelect, .ramSelect,
   .peripheralSelect, .chip_select_low_region_n, .chip_select_high_region_n, .targetWrite, .extAddr, .localAddr,
   .reservedHit, .systemHit, .unmappedHit, .modeOut);

// [bench/asd_cpu_model.sv]
// Purpose: cpu core bus master issuing one-cycle requests
// Assumes: requests are changed 1 ns after the rising edge
// Notes:   between requests the bus shows the inverse so a stale address never matches
`timescale 1ns/1ns
module asd_cpu_model (
   input  wire logic        sys_clk,
   output logic             reqValid,
   output logic             reqWrite,
   output logic [31:0]      reqAddr
);
   initial begin
      reqValid = 1'h0;
      reqWrite = 1'h0;
      reqAddr  = 32'h0;
   end
   // reserved and system addresses go out with reqValid high only when a scenario asks for them
   task automatic issue(input logic [31:0] addr, input logic wr);
      @(posedge sys_clk);
      #1;
      reqValid = 1'h1;
      reqWrite = wr;
      reqAddr  = addr;
      @(posedge sys_clk);
      #1;
      reqValid = 1'h0;
      reqWrite = ~wr;
      reqAddr  = ~addr;
   endtask
endmodule

// [bench/address_space_decoder_tb_top.sv]
// Purpose: directed bench of the address space decoder in every legal mode
// Assumes: selects show one cycle after the request edge
// Notes:   each mode needs its own reset since straps latch once
`timescale 1ns/1ns
module address_space_decoder_tb_top;
   logic        sys_clk, reset, mode_strap_a, mode_strap_b;
   logic        romSelect, ramSelect, peripheralSelect, targetWrite, reservedHit, systemHit, unmappedHit;
   logic        chip_select_low_region_n, chip_select_high_region_n, extReadStrobe_n, extWriteStrobe_n;
   logic [19:0] extAddr;
   logic [13:0] localAddr;
   logic [1:0]  modeOut;
   wire logic   reqValid, reqWrite;
   wire logic [31:0] reqAddr;
   int          errors = 0;
   int          comparisons = 0;
   asd_cpu_model u_asd_cpu_model (.sys_clk, .reqValid, .reqWrite, .reqAddr);
   address_space_decoder u_address_space_decoder (.sys_clk, .reset, .mode_strap_a, .mode_strap_b, .reqValid,
      .reqWrite, .reqAddr, .romSelect, .ramSelect, .peripheralSelect, .chip_select_low_region_n,
      .chip_select_high_region_n, .extReadStrobe_n, .extWriteStrobe_n, .targetWrite, .extAddr, .localAddr,
      .reservedHit, .systemHit, .unmappedHit, .modeOut);
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic start_mode(input logic a, input logic b);
      reset = 1'h1;
      mode_strap_a = a;
      mode_strap_b = b;
      repeat (5) @(posedge sys_clk);
      #1;
      reset = 1'h0;
   endtask
   // exp = {rom, ram, peripheral, low cs, high cs, reserved, system, unmapped}
   task automatic access(input logic [31:0] a, input logic wr, input logic [7:0] exp);
      logic       ext;
      logic [7:0] got;
      u_asd_cpu_model.issue(a, wr);
      ext = exp[4] | exp[3];
      got = {romSelect, ramSelect, peripheralSelect, ~chip_select_low_region_n, ~chip_select_high_region_n,
             reservedHit, systemHit, unmappedHit};
      comparisons++;
      if (got !== exp || targetWrite !== (wr & (|exp[7:3])) || extWriteStrobe_n !== ~(wr & ext)
          || extReadStrobe_n !== ~(~wr & ext) || (ext && extAddr !== a[19:0])
          || ((|exp[6:5]) && localAddr !== a[13:0])) begin
         errors++;
         $display("[ERR] %0t addr %h selects %b", $time, a, got);
      end
   endtask
   task automatic check_mode(input logic [1:0] m);
      comparisons++;
      if (modeOut !== m) begin
         errors++;
         $display("[ERR] %0t mode %b", $time, modeOut);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_single;
      start_mode(1'h0, 1'h0);
      access(32'h0000_0000, 1'h0, 8'h80);
      check_mode(2'h0);
      access(32'h0001_FFFE, 1'h1, 8'h80);
      access(32'h0002_0000, 1'h0, 8'h01);
      access(32'h000F_0000, 1'h1, 8'h01);
      access(32'h0070_0010, 1'h0, 8'h80);
      access(32'h0080_1000, 1'h1, 8'h40);
   endtask
   task automatic test_expand;
      start_mode(1'h0, 1'h1);
      access(32'h0000_0100, 1'h0, 8'h80);
      check_mode(2'h1);
      access(32'h0002_0000, 1'h1, 8'h10);
      access(32'h0007_FFFF, 1'h0, 8'h10);
      access(32'h0008_0000, 1'h1, 8'h08);
      access(32'h003F_FFFC, 1'h0, 8'h08);
      access(32'h0080_0004, 1'h0, 8'h20);
   endtask
   task automatic test_proc;
      start_mode(1'h1, 1'h0);
      access(32'h0000_0000, 1'h0, 8'h10);
      check_mode(2'h2);
      access(32'h0007_FFFF, 1'h1, 8'h10);
      access(32'h000F_FFFF, 1'h0, 8'h08);
      // straps moved after capture must not move the map until the next reset
      mode_strap_a = 1'h0;
      mode_strap_b = 1'h1;
      access(32'h0000_0000, 1'h1, 8'h10);
      check_mode(2'h2);
   endtask
   task automatic test_ramreg;
      access(32'h0080_0000, 1'h0, 8'h20);
      access(32'h0080_0FFF, 1'h1, 8'h20);
      access(32'h0080_1000, 1'h1, 8'h40);
      access(32'h0080_27FF, 1'h0, 8'h40);
      access(32'h0080_2800, 1'h1, 8'h01);
      access(32'h00FF_D004, 1'h0, 8'h40);
   endtask
   task automatic test_areas;
      access(32'h8000_0000, 1'h1, 8'h04);
      access(32'hBFFF_FFFF, 1'h0, 8'h04);
      access(32'hC000_0000, 1'h1, 8'h02);
      access(32'hFFFF_FFFC, 1'h0, 8'h02);
      access(32'h7FFF_FFF0, 1'h0, 8'h01);
      access(32'h0100_0000, 1'h1, 8'h01);
   endtask
   initial begin
      reset = 1'h1;
      mode_strap_a = 1'h0;
      mode_strap_b = 1'h0;
      test_single();
      test_expand();
      test_proc();
      test_ramreg();
      test_areas();
      report_and_stop();
   end
   // the whole run is about 70 cycles
   initial begin
      repeat (2000) @(posedge sys_clk);
      errors++;
      report_and_stop();
   end
endmodule
